// ==== design/sbcr_top.sv ====
// status and cell balance register bank behind a mode-0 serial port
`timescale 1ns/1ps
module sbcr_top
  import sbcr_pkg::*;
(
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       srst_i,
  // serial host pins
  input  wire logic       spi_sclk_i,
  input  wire logic       spi_cs_n_i,
  input  wire logic       spi_mosi_i,
  output logic            spi_miso_o,
  output logic            spi_miso_oe_n_o,
  // mirrored device state
  input  wire logic       discharge_fet_drive_i,
  input  wire logic       charge_fet_drive_i,
  input  wire logic       power_save_flag_i,
  input  wire logic       irq_n_i,
  input  wire logic       charger_off_overcurrent_irq_i,
  input  wire logic       charger_off_powerdown_irq_i,
  input  wire logic       load_open_irq_flag_i,
  // short-current flag control
  input  wire logic       short_irq_enable_i,
  input  wire logic       short_delay_done_i,
  input  wire logic       short_flag_clear_i,
  // outputs
  output logic            short_irq_flag_o,
  output logic            fet_force_off_o,
  output logic [7:0]      balance_upper_bits_o,
  output logic [7:0]      balance_lower_bits_o
);
  // frame: bit15 write flag, 7 address bits, then 8 data bits, msb first
  // ==========================================================
  // pin synchronisers
  logic sclk_s, sclk_rise, sclk_fall;
  logic cs_n_s, cs_sel_s;
  logic mosi_s;
  logic [6:0] st_s;
  logic [6:0] st_raw;

  sbcr_sync u_sclk (.clock_i(clock_i), .srst_i(srst_i), .d_i(spi_sclk_i),
                    .q_o(sclk_s), .rise_o(sclk_rise), .fall_o(sclk_fall));
  // synced as select, so reset reads as deselected and miso stays released
  sbcr_sync u_cs (.clock_i(clock_i), .srst_i(srst_i), .d_i(~spi_cs_n_i),
                  .q_o(cs_sel_s), .rise_o(), .fall_o());
  assign cs_n_s = ~cs_sel_s;
  sbcr_sync u_mosi (.clock_i(clock_i), .srst_i(srst_i), .d_i(spi_mosi_i),
                    .q_o(mosi_s), .rise_o(), .fall_o());

  assign st_raw = {load_open_irq_flag_i, charger_off_powerdown_irq_i,
                   charger_off_overcurrent_irq_i, ~irq_n_i, power_save_flag_i,
                   charge_fet_drive_i, discharge_fet_drive_i};

  // state inputs come from another domain, so sync each bit
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_st
      sbcr_sync u_st (.clock_i(clock_i), .srst_i(srst_i), .d_i(st_raw[gi]),
                      .q_o(st_s[gi]), .rise_o(), .fall_o());
    end
  endgenerate

  // ==========================================================
  // serial shift engine
  logic [4:0]  bit_cnt_q;
  logic [15:0] shift_q;
  logic [7:0]  tx_q;
  logic        wr_frame;
  logic [6:0]  frame_addr;
  logic [7:0]  rd_data;
  logic [7:0]  status_word;
  logic        frame_done;

  assign frame_addr = shift_q[14:8];
  assign wr_frame   = shift_q[15];
  // last data bit sampled on this rise
  assign frame_done = sclk_rise & ~cs_n_s & (bit_cnt_q == 5'(SBCR_FRAME_BITS - 1));

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      bit_cnt_q <= SBCR_CNT_ZERO;
      shift_q   <= 16'h0000;
    end else if (cs_n_s) begin
      bit_cnt_q <= SBCR_CNT_ZERO;
    end else if (sclk_rise && bit_cnt_q != 5'(SBCR_FRAME_BITS)) begin
      shift_q   <= {shift_q[14:0], mosi_s};
      bit_cnt_q <= bit_cnt_q + 5'd1;
    end
  end

  // ==========================================================
  // short-current flag
  logic short_q;
  logic force_q;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      short_q <= 1'b0;
      force_q <= 1'b0;
    end else begin
      if (!short_irq_enable_i) begin
        short_q <= 1'b0;
      end else if (short_delay_done_i) begin
        short_q <= 1'b1;
      end else if (short_flag_clear_i) begin
        short_q <= 1'b0;
      end
      force_q <= short_delay_done_i;
    end
  end

  assign short_irq_flag_o = short_q;
  assign fet_force_off_o  = force_q;

  assign status_word = {short_q, st_s[6:0]};

  // ==========================================================
  // balance registers
  logic [7:0] bal_up_q;
  logic [7:0] bal_lo_q;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;

  assign wr_addr = shift_q[13:7];
  assign wr_data = {shift_q[6:0], mosi_s};

  // header bit order: write flag first, then address
  logic hdr_wr;
  assign hdr_wr = shift_q[14];

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      bal_up_q <= SBCR_RST_VALUE;
      bal_lo_q <= SBCR_RST_VALUE;
    end else if (frame_done && hdr_wr) begin
      if (wr_addr == SBCR_ADDR_BAL_UP) begin
        bal_up_q <= wr_data;
      end
      if (wr_addr == SBCR_ADDR_BAL_LO) begin
        bal_lo_q <= wr_data;
      end
    end
  end

  // each bit drives its own switch, no interlock
  assign balance_upper_bits_o = bal_up_q;
  assign balance_lower_bits_o = bal_lo_q;

  // ==========================================================
  // read path
  always_comb begin
    unique case (shift_q[6:0])
      SBCR_ADDR_STATUS: rd_data = status_word;
      SBCR_ADDR_BAL_UP: rd_data = bal_up_q;
      SBCR_ADDR_BAL_LO: rd_data = bal_lo_q;
      default:          rd_data = 8'h00;
    endcase
  end

  logic miso_q;
  logic oe_n_q;

  // data shifts out on falling edges after the 8 header bits
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      tx_q   <= 8'h00;
      miso_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else if (cs_n_s) begin
      oe_n_q <= 1'b1;
      miso_q <= 1'b0;
    end else begin
      oe_n_q <= 1'b0;
      if (sclk_fall && bit_cnt_q == 5'd8) begin
        tx_q   <= {rd_data[6:0], 1'b0};
        miso_q <= rd_data[7];
      end else if (sclk_fall && bit_cnt_q > 5'd8) begin
        miso_q <= tx_q[7];
        tx_q   <= {tx_q[6:0], 1'b0};
      end
    end
  end

  assign spi_miso_o      = miso_q;
  assign spi_miso_oe_n_o = oe_n_q;

  // ==========================================================
  // checks
  AST_BAL_WRITE: assert property (@(posedge clock_i) disable iff (srst_i)
    frame_done && hdr_wr && wr_addr == SBCR_ADDR_BAL_UP |=> bal_up_q == $past(wr_data))
    else $error("upper balance write lost");
  AST_BAL_LO: assert property (@(posedge clock_i) disable iff (srst_i)
    frame_done && hdr_wr && wr_addr == SBCR_ADDR_BAL_LO |=> bal_lo_q == $past(wr_data))
    else $error("lower balance write lost");
  AST_BAL_HOLD: assert property (@(posedge clock_i) disable iff (srst_i)
    !frame_done |=> $stable(bal_up_q) && $stable(bal_lo_q))
    else $error("balance changed without write");
  AST_SC_SET: assert property (@(posedge clock_i) disable iff (srst_i)
    short_irq_enable_i && short_delay_done_i |=> short_q && force_q)
    else $error("short flag or fet kill missing");
  AST_SC_GATE: assert property (@(posedge clock_i) disable iff (srst_i)
    !short_irq_enable_i |=> !short_q)
    else $error("short flag set while disabled");
  AST_SC_CLR: assert property (@(posedge clock_i) disable iff (srst_i)
    short_q && short_flag_clear_i && !short_delay_done_i |=> !short_q)
    else $error("short flag not cleared");
  AST_ST_MSB: assert property (@(posedge clock_i) disable iff (srst_i)
    !$past(short_irq_enable_i) |-> !status_word[SBCR_ST_RSC])
    else $error("status bit 7 set while disabled");
  AST_ST_CF: assert property (@(posedge clock_i) disable iff (srst_i)
    $rose(charge_fet_drive_i) ##3 charge_fet_drive_i |-> status_word[SBCR_ST_CF])
    else $error("status cf late");
  AST_ST_DF_OFF: assert property (@(posedge clock_i) disable iff (srst_i)
    $fell(discharge_fet_drive_i) ##3 !discharge_fet_drive_i |-> !status_word[SBCR_ST_DF])
    else $error("status df stuck on");
  AST_ST_PSV: assert property (@(posedge clock_i) disable iff (srst_i)
    $rose(power_save_flag_i) ##3 power_save_flag_i |-> status_word[SBCR_ST_PSV])
    else $error("status psv late");
  AST_ST_PSL: assert property (@(posedge clock_i) disable iff (srst_i)
    $rose(charger_off_overcurrent_irq_i) ##3 charger_off_overcurrent_irq_i |-> status_word[SBCR_ST_PSL])
    else $error("status bit 4 late");
  AST_ST_PSH: assert property (@(posedge clock_i) disable iff (srst_i)
    $rose(charger_off_powerdown_irq_i) ##3 charger_off_powerdown_irq_i |-> status_word[SBCR_ST_PSH])
    else $error("status bit 5 late");
  AST_ST_RRS: assert property (@(posedge clock_i) disable iff (srst_i)
    $rose(load_open_irq_flag_i) ##3 load_open_irq_flag_i |-> status_word[SBCR_ST_RRS])
    else $error("status bit 6 late");
  AST_ST_NOWR: assert property (@(posedge clock_i) disable iff (srst_i)
    frame_done && hdr_wr && wr_addr == SBCR_ADDR_STATUS |=> $stable(bal_up_q) && $stable(bal_lo_q))
    else $error("status write touched balance");
  AST_FET_KILL: assert property (@(posedge clock_i) disable iff (srst_i)
    short_delay_done_i |=> fet_force_off_o)
    else $error("fet kill missing");
  AST_MISO_IDLE: assert property (@(posedge clock_i) disable iff (srst_i)
    cs_n_s |=> spi_miso_oe_n_o)
    else $error("miso driven while deselected");
  AST_ST_DF: assert property (@(posedge clock_i) disable iff (srst_i)
    $rose(discharge_fet_drive_i) ##3 discharge_fet_drive_i |-> status_word[SBCR_ST_DF])
    else $error("status df late");
  AST_ST_INT: assert property (@(posedge clock_i) disable iff (srst_i)
    $fell(irq_n_i) ##3 !irq_n_i |-> status_word[SBCR_ST_INT])
    else $error("status int late");
endmodule

// ==== design/sbcr_pkg.sv ====
// constants for the status and cell balance register block
// Functional notes
// - read-only status at 0x07, resets zero
// - bits 0/1 mirror discharge/charge FET drive
// - bit 2 shows power-save state
// - bit 3 shows interrupt pin asserted
// - bit 4 charger-off overcurrent flag pending
// - bit 5 charger-off power-down flag pending
// - bit 6 load-open flag pending
// - bit 7 short-current flag pending
// - upper balance register 0x08, cells 9-16
// - lower balance register 0x09, cells 1-8
// - any balance bit combination allowed
// - short flag cleared by zero write, gated; here a status write is ignored and short_flag_clear_i clears it
// - short delay done sets flag (only while short_irq_enable_i is high), FETs off
package sbcr_pkg;
  localparam logic [6:0] SBCR_ADDR_STATUS = 7'h07;
  localparam logic [6:0] SBCR_ADDR_BAL_UP = 7'h08;
  localparam logic [6:0] SBCR_ADDR_BAL_LO = 7'h09;
  localparam logic [7:0] SBCR_RST_VALUE   = 8'h00;
  localparam int SBCR_ST_DF   = 0;
  localparam int SBCR_ST_CF   = 1;
  localparam int SBCR_ST_PSV  = 2;
  localparam int SBCR_ST_INT  = 3;
  localparam int SBCR_ST_PSL  = 4;
  localparam int SBCR_ST_PSH  = 5;
  localparam int SBCR_ST_RRS  = 6;
  localparam int SBCR_ST_RSC  = 7;
  localparam int SBCR_FRAME_BITS = 16;
  localparam logic [4:0] SBCR_CNT_ZERO = 5'h00;
endpackage

// ==== design/sbcr_sync.sv ====
// two-flop synchroniser with edge outputs
`timescale 1ns/1ps
module sbcr_sync (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic srst_i,
  // async level in
  input  wire logic d_i,
  // synced level and edges
  output logic      q_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign q_o    = sync_q;
  assign rise_o = sync_q & ~last_q;
  assign fall_o = ~sync_q & last_q;
endmodule

// ==== sim/sbcr_host_model.sv ====
// serial host model driving the register bank
`timescale 1ns/1ps
module sbcr_host_model (
  // serial pins
  output logic      spi_sclk_o,
  output logic      spi_cs_n_o,
  output logic      spi_mosi_o,
  input  wire logic spi_miso_i
);
  initial begin
    spi_sclk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_mosi_o = 1'b0;
  end
  function automatic bit legal(input logic [15:0] v);
    return ((v & (v << 1)) == 0) && ((v & (v << 2)) == 0) && ($countones(v) <= 4);
  endfunction
  // long low phase leaves miso settled before the sampling rise
  task automatic xfer(input logic [15:0] frm, output logic [7:0] rd);
    // keep pin changes off the sampling edge
    #2;
    rd = 8'h00;
    spi_cs_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi_o = frm[i];
      #100 spi_sclk_o = 1'b1;
      if (i < 8) rd = {rd[6:0], spi_miso_i};
      #60 spi_sclk_o = 1'b0;
    end
    #100 spi_cs_n_o = 1'b1;
    spi_mosi_o = ~spi_mosi_o;
    #100;
  endtask
endmodule

// ==== sim/sbcr_top_tb.sv ====
// self-checking bench for the register bank
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module sbcr_top_tb;
  import sbcr_pkg::*;
  logic       clock_i = 1'b0;
  logic       srst_i  = 1'b1;
  // status bits 0..6, bit 3 as asserted level
  logic [6:0] st_in   = 7'h00;
  logic       sc_en   = 1'b0;
  logic       sc_done = 1'b0;
  logic       sc_clr  = 1'b0;
  wire logic  sclk, cs_n, mosi, miso, oe_n, flag, fet_off, miso_w;
  wire logic [7:0] bal_up, bal_lo;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed = 46092;
  logic [7:0]  mreg [7:9];
  logic [7:0]  rd;
  logic [15:0] v;
  always #10 clock_i = ~clock_i;
  // released line shows inverse of miso, which clears to 0 on deselect, so it reads high
  assign miso_w = oe_n ? ~miso : miso;
  sbcr_host_model host (.spi_sclk_o(sclk), .spi_cs_n_o(cs_n), .spi_mosi_o(mosi), .spi_miso_i(miso_w));
  sbcr_top dut (.clock_i(clock_i), .srst_i(srst_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_n_o(oe_n),
    .discharge_fet_drive_i(st_in[0]), .charge_fet_drive_i(st_in[1]), .power_save_flag_i(st_in[2]),
    .irq_n_i(~st_in[3]), .charger_off_overcurrent_irq_i(st_in[4]),
    .charger_off_powerdown_irq_i(st_in[5]), .load_open_irq_flag_i(st_in[6]),
    .short_irq_enable_i(sc_en), .short_delay_done_i(sc_done), .short_flag_clear_i(sc_clr),
    .short_irq_flag_o(flag), .fet_force_off_o(fet_off),
    .balance_upper_bits_o(bal_up), .balance_lower_bits_o(bal_lo));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic rw(input logic wr, input logic [6:0] a, input logic [7:0] d);
    host.xfer({wr, a, d}, rd);
    if (wr && (a == SBCR_ADDR_BAL_UP || a == SBCR_ADDR_BAL_LO)) mreg[a] = d;
    repeat (4) @(posedge clock_i);
  endtask
  task automatic chk_rd(input logic [6:0] a, input logic [7:0] e);
    rw(1'b0, a, 8'h00);
    `CHK(rd, e)
  endtask
  task automatic pulse_done;
    @(posedge clock_i);
    #2 sc_done = 1'b1;
    @(posedge clock_i);
    #1 `CHK(fet_off, 1'b1)
    #1 sc_done = 1'b0;
    repeat (3) @(posedge clock_i);
  endtask
  always @(posedge clock_i) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      give_verdict();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    mreg[8] = 8'h00;
    mreg[9] = 8'h00;
    repeat (2) @(posedge clock_i);
    #2 srst_i = 1'b0;
    repeat (4) @(posedge clock_i);
    #1 `CHK(oe_n, 1'b1)
    chk_rd(SBCR_ADDR_STATUS, 8'h00);
    chk_rd(SBCR_ADDR_BAL_UP, 8'h00);
    chk_rd(SBCR_ADDR_BAL_LO, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      v = 16'($random(seed) & $random(seed));
      while (!host.legal(v)) v = 16'($random(seed) & $random(seed));
      rw(1'b1, SBCR_ADDR_BAL_UP, v[15:8]);
      rw(1'b1, SBCR_ADDR_BAL_LO, v[7:0]);
      `CHK(bal_up, mreg[8])
      `CHK(bal_lo, mreg[9])
      chk_rd(SBCR_ADDR_BAL_UP, mreg[8]);
    end
    $display("test balance done");
    for (int i = 0; i < 10; i++) begin
      @(posedge clock_i);
      #2 st_in = 7'((i < 7) ? (1 << i) : $random(seed));
      chk_rd(SBCR_ADDR_STATUS, {1'b0, st_in});
    end
    $display("test status done");
    rw(1'b1, SBCR_ADDR_STATUS, 8'hff);
    chk_rd(SBCR_ADDR_STATUS, {1'b0, st_in});
    rw(1'b1, 7'h0a, 8'h55);
    chk_rd(7'h0a, 8'h00);
    chk_rd(SBCR_ADDR_BAL_LO, mreg[9]);
    $display("test refused done");
    pulse_done();
    `CHK(flag, 1'b0)
    #2 sc_en = 1'b1;
    pulse_done();
    chk_rd(SBCR_ADDR_STATUS, {1'b1, st_in});
    @(posedge clock_i);
    #2 sc_clr = 1'b1;
    @(posedge clock_i);
    #2 sc_clr = 1'b0;
    repeat (3) @(posedge clock_i);
    `CHK(flag, 1'b0)
    pulse_done();
    `CHK(flag, 1'b1)
    #2 sc_en = 1'b0;
    repeat (3) @(posedge clock_i);
    `CHK(flag, 1'b0)
    $display("test short flag done");
    give_verdict();
  end
endmodule
